// ---- hdl/scrd_top.sv ----
`timescale 1ns/1ps
module scrd_top
  import scrd_pkg::*;
(
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    spi_sck_i,
  input  wire logic                    spi_cs_n_i,
  input  wire logic                    spi_sdi_i,
  output logic                         spi_sdo_o,
  output logic                         spi_sdo_oe_o,
  input  wire scrd_pkg::scrd_evt_s     evt_i,
  input  wire scrd_pkg::scrd_live_s    live_i,
  input  wire logic [scrd_pkg::PARAM_W-1:0] rx_byte_i,
  output logic                         rx_byte_taken_o,
  output logic [scrd_pkg::PARAM_W-1:0] tx_byte_o,
  output logic                         tx_byte_valid_o,
  output scrd_pkg::scrd_cfg_t          cfg_o,
  output scrd_pkg::scrd_gen_cfg_s      gen_cfg_o,
  output scrd_pkg::scrd_buf_cfg_s      buf_cfg_o,
  output scrd_pkg::scrd_pwr_cfg_s      pwr_cfg_o,
  output scrd_pkg::scrd_status_s       status_o
);
  import scrd_pkg::*;

  typedef struct packed {
    scrd_cfg_t          cfg;
    scrd_evt_s          flags;
    logic [WORD_W-1:0]  st_snap;
    logic [PARAM_W-1:0] rx_snap;
    logic               cs_prev;
    logic               word_seen;
    logic               bad_seen;
    logic [PARAM_W-1:0] tx_byte;
    logic               tx_valid;
    logic               rx_taken;
  } scrd_core_s;

  scrd_core_s        s_r;
  scrd_core_s        s_nxt;
  logic [WORD_W-1:0] link_word;
  logic              link_wtgl;
  logic              link_btgl;
  logic              cs_high;
  logic              wtgl_sync;
  logic              btgl_sync;
  logic              cs_rise;
  logic              commit;
  scrd_cmd_e         cmd;
  scrd_status_s      status_live;
  scrd_status_s      snap_view;
  scrd_evt_s         clr_mask;

  // serial side, clocked by the host clock
  scrd_spi_link u_link (
    .sck_i         (spi_sck_i),
    .rst_i         (rst_i),
    .cs_n_i        (spi_cs_n_i),
    .sdi_i         (spi_sdi_i),
    .status_snap_i (s_r.st_snap),
    .rx_snap_i     (s_r.rx_snap),
    .word_o        (link_word),
    .word_tgl_o    (link_wtgl),
    .bad_tgl_o     (link_btgl),
    .sdo_o         (spi_sdo_o),
    .sdo_oe_o      (spi_sdo_oe_o)
  );

  scrd_sync #(.W(1), .RST_VAL(1'b1)) u_cs_sync (
    .clk_i (core_clk_i),
    .rst_i (rst_i),
    .d_i   (spi_cs_n_i),
    .q_o   (cs_high)
  );

  scrd_sync #(.W(2), .RST_VAL(1'b0)) u_tgl_sync (
    .clk_i (core_clk_i),
    .rst_i (rst_i),
    .d_i   ({link_wtgl, link_btgl}),
    .q_o   ({wtgl_sync, btgl_sync})
  );

  assign status_live = {s_r.flags, live_i};
  assign snap_view   = s_r.st_snap;
  // link word is stable once its toggle has been seen and the clock has stopped
  assign cmd         = scrd_decode(link_word);
  assign cs_rise     = cs_high & ~s_r.cs_prev;
  assign commit      = cs_rise & (wtgl_sync != s_r.word_seen) & (btgl_sync == s_r.bad_seen);

  always_comb begin
    s_nxt          = s_r;
    s_nxt.tx_valid = 1'b0;
    s_nxt.rx_taken = 1'b0;
    s_nxt.cs_prev  = cs_high;
    clr_mask       = '0;
    if (cs_rise) begin
      s_nxt.word_seen = wtgl_sync;
      s_nxt.bad_seen  = btgl_sync;
    end
    // snapshot follows live state only while deselected
    if (cs_high) begin
      s_nxt.st_snap = status_live;
      s_nxt.rx_snap = rx_byte_i;
    end
    if (commit) begin
      case (cmd)
        CMD_STATUS: begin
          clr_mask = snap_view.evt;
        end
        CMD_TX_BYTE: begin
          s_nxt.tx_byte  = link_word[PARAM_W-1:0];
          s_nxt.tx_valid = 1'b1;
        end
        CMD_RX_READ: begin
          s_nxt.rx_taken = 1'b1;
        end
        CMD_NONE: begin
        end
        default: begin
          s_nxt.cfg[cmd[3:0]] = link_word[PARAM_W-1:0];
        end
      endcase
    end
    // only reported flags clear; a new event wins over the clear
    s_nxt.flags = (s_r.flags & ~clr_mask) | evt_i;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r         <= '0;
      s_r.cfg     <= CFG_DEFAULT;
      s_r.cs_prev <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // configuration leaves only toward the radio, never back to the serial port
  assign cfg_o           = s_r.cfg;
  assign gen_cfg_o       = scrd_gen_cfg_s'(s_r.cfg[CMD_GENERAL]);
  assign buf_cfg_o       = scrd_buf_cfg_s'(s_r.cfg[CMD_BUF_RESET]);
  assign pwr_cfg_o       = scrd_pwr_cfg_s'(s_r.cfg[CMD_POWER]);
  assign status_o        = s_r.st_snap;
  assign tx_byte_o       = s_r.tx_byte;
  assign tx_byte_valid_o = s_r.tx_valid;
  assign rx_byte_taken_o = s_r.rx_taken;
endmodule

// ---- shared/scrd_pkg.sv ----
package scrd_pkg;

  localparam int WORD_W       = 16;
  localparam int PARAM_W      = 8;
  localparam int NUM_CFG      = 14;
  localparam int CNT_W        = 5;
  localparam int CODE_PFX_LSB = 12;
  localparam int CODE_IDX_LSB = 8;
  localparam int NUM_EVT      = 5;

  localparam logic [3:0]       CMD_PREFIX     = 4'h8;
  localparam logic             STATUS_LEAD    = 1'b0;
  localparam logic [CNT_W-1:0] CNT_ZERO       = 5'h00;
  localparam logic [CNT_W-1:0] CNT_CODE_LAST  = 5'h07;
  localparam logic [CNT_W-1:0] CNT_WORD_LAST  = 5'h0f;
  localparam logic [CNT_W-1:0] CNT_WORD_FULL  = 5'h10;
  localparam logic [CNT_W-1:0] CNT_OVER       = 5'h11;
  localparam logic [CNT_W-1:0] CNT_ONE        = 5'h01;
  localparam logic [PARAM_W-1:0] PARAM_ZERO   = 8'h00;

  typedef enum logic [4:0] {
    CMD_GENERAL, CMD_FREQ_TRACK, CMD_TX_CONFIG, CMD_CENTER_FREQ, CMD_RX_CONTROL,
    CMD_BB_FILTER, CMD_BUF_RESET, CMD_SYNC_PAT, CMD_BIT_RATE, CMD_POWER,
    CMD_WAKE_PERIOD, CMD_DUTY_CYCLE, CMD_SUPPLY_CLK, CMD_SYNTH,
    CMD_TX_BYTE, CMD_RX_READ, CMD_STATUS, CMD_NONE
  } scrd_cmd_e;

  typedef logic [NUM_CFG-1:0][PARAM_W-1:0] scrd_cfg_t;

  // defaults, index 13 (synth) down to 0 (general)
  localparam scrd_cfg_t CFG_DEFAULT = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
  };

  typedef struct packed {
    logic [1:0] band_sel;
    logic       tx_reg_en;
    logic       rx_buf_en;
    logic [3:0] load_cap;
  } scrd_gen_cfg_s;

  typedef struct packed {
    logic [3:0] irq_level;
    logic       sync_len;
    logic       start_ctl;
    logic       buf_en;
    logic       reset_sens;
  } scrd_buf_cfg_s;

  typedef struct packed {
    logic rx_chain_en;
    logic bb_en;
    logic tx_chain_en;
    logic synth_en;
    logic osc_en;
    logic low_supply_det_en;
    logic wake_timer_en;
    logic clk_out_en;
  } scrd_pwr_cfg_s;

  typedef struct packed {
    logic txrx_ready_flag;
    logic por_flag;
    logic overrun_underrun_flag;
    logic wake_timer_flag;
    logic external_edge_flag;
  } scrd_evt_s;

  typedef struct packed {
    logic       low_supply_flag;
    logic       buffer_empty_flag;
    logic       signal_strength_flag;
    logic       data_quality_flag;
    logic       clock_recovery_lock_flag;
    logic       freq_tracking_toggle;
    logic       offset_sign;
    logic [3:0] freq_offset_field;
  } scrd_live_s;

  typedef struct packed {
    scrd_evt_s  evt;
    scrd_live_s live;
  } scrd_status_s;

  function automatic scrd_cmd_e scrd_decode(input logic [WORD_W-1:0] w);
    if (w[WORD_W-1] == STATUS_LEAD) begin
      return CMD_STATUS;
    end else if (w[CODE_PFX_LSB +: 4] == CMD_PREFIX) begin
      return scrd_cmd_e'({1'b0, w[CODE_IDX_LSB +: 4]});
    end
    return CMD_NONE;
  endfunction

endpackage

// ---- hdl/scrd_sync.sv ----
`timescale 1ns/1ps
module scrd_sync #(
  parameter int   W       = 1,
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } scrd_sync_s;

  scrd_sync_s s_r;
  scrd_sync_s s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.meta = d_i;
    s_nxt.sync = s_r.meta;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= {(2 * W){RST_VAL}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q_o = s_r.sync;
endmodule

// ---- hdl/scrd_spi_link.sv ----
`timescale 1ns/1ps
module scrd_spi_link
  import scrd_pkg::*;
(
  input  wire logic                           sck_i,
  input  wire logic                           rst_i,
  input  wire logic                           cs_n_i,
  input  wire logic                           sdi_i,
  input  wire logic [scrd_pkg::WORD_W-1:0]    status_snap_i,
  input  wire logic [scrd_pkg::PARAM_W-1:0]   rx_snap_i,
  output logic      [scrd_pkg::WORD_W-1:0]    word_o,
  output logic                                word_tgl_o,
  output logic                                bad_tgl_o,
  output logic                                sdo_o,
  output logic                                sdo_oe_o
);
  import scrd_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0]  cnt;
    logic [WORD_W-1:0] shin;
    logic [WORD_W-1:0] sout;
  } scrd_frame_s;

  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic              wtgl;
    logic              btgl;
  } scrd_held_s;

  scrd_frame_s f_r;
  scrd_frame_s f_nxt;
  scrd_held_s  h_r;
  scrd_held_s  h_nxt;
  logic        frame_rst;
  logic        sdo_r;
  logic [WORD_W-1:0] code_word;

  assign frame_rst = rst_i | cs_n_i;
  assign code_word = {f_r.shin[CNT_CODE_LAST - 1:0], sdi_i, PARAM_ZERO};

  always_comb begin
    f_nxt      = f_r;
    h_nxt      = h_r;
    f_nxt.shin = {f_r.shin[WORD_W-2:0], sdi_i};
    f_nxt.sout = {f_r.sout[WORD_W-2:0], 1'b0};
    if (f_r.cnt != CNT_OVER) begin
      f_nxt.cnt = f_r.cnt + CNT_ONE;
    end
    if (f_r.cnt == CNT_ZERO && sdi_i == STATUS_LEAD) begin
      f_nxt.sout = status_snap_i;
    end
    if (f_r.cnt == CNT_CODE_LAST && scrd_decode(code_word) == CMD_RX_READ) begin
      f_nxt.sout = {rx_snap_i, PARAM_ZERO};
    end
    if (f_r.cnt == CNT_WORD_LAST) begin
      h_nxt.word = {f_r.shin[WORD_W-2:0], sdi_i};
      h_nxt.wtgl = ~h_r.wtgl;
    end
    if (f_r.cnt == CNT_WORD_FULL) begin
      h_nxt.btgl = ~h_r.btgl;
    end
  end

  // frame logic is cleared by chip select, the clock stops between frames
  always_ff @(posedge sck_i or posedge frame_rst) begin
    if (frame_rst) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  always_ff @(posedge sck_i or posedge rst_i) begin
    if (rst_i) begin
      h_r <= '0;
    end else begin
      h_r <= h_nxt;
    end
  end

  always_ff @(negedge sck_i or posedge frame_rst) begin
    if (frame_rst) begin
      sdo_r <= 1'b0;
    end else begin
      sdo_r <= f_r.sout[WORD_W-1];
    end
  end

  assign word_o     = h_r.word;
  assign word_tgl_o = h_r.wtgl;
  assign bad_tgl_o  = h_r.btgl;
  assign sdo_o      = sdo_r;
  assign sdo_oe_o   = ~cs_n_i;
endmodule

// ---- bench/scrd_chk.sv ----
`timescale 1ns/1ps
module scrd_chk
  import scrd_pkg::*;
(
  input wire logic                 core_clk_i,
  input wire logic                 rst_i,
  input wire logic                 spi_cs_n_i,
  input wire logic                 spi_sdo_o,
  input wire logic                 spi_sdo_oe_o,
  input wire logic                 rx_byte_taken_o,
  input wire logic                 tx_byte_valid_o,
  input wire scrd_pkg::scrd_cfg_t     cfg_o,
  input wire scrd_pkg::scrd_gen_cfg_s gen_cfg_o,
  input wire scrd_pkg::scrd_buf_cfg_s buf_cfg_o,
  input wire scrd_pkg::scrd_pwr_cfg_s pwr_cfg_o,
  input wire scrd_pkg::scrd_status_s  status_o
);
  import scrd_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  property p_oe; spi_sdo_oe_o == !spi_cs_n_i; endproperty
  a_oe: assert property (p_oe) else $error("sdo enable wrong");
  property p_idle; spi_cs_n_i |-> !spi_sdo_o; endproperty
  a_idle: assert property (p_idle) else $error("sdo not low");
  property p_cfg; !$stable(cfg_o) |-> spi_cs_n_i; endproperty
  a_cfg: assert property (p_cfg) else $error("cfg changed in frame");
  property p_gen; gen_cfg_o == cfg_o[0]; endproperty
  a_gen: assert property (p_gen) else $error("general view wrong");
  property p_buf; buf_cfg_o == cfg_o[6]; endproperty
  a_buf: assert property (p_buf) else $error("buffer view wrong");
  property p_pwr; pwr_cfg_o == cfg_o[9]; endproperty
  a_pwr: assert property (p_pwr) else $error("power view wrong");
  property p_tx; tx_byte_valid_o |-> spi_cs_n_i && $stable(cfg_o) ##1 !tx_byte_valid_o; endproperty
  a_tx: assert property (p_tx) else $error("tx pulse wrong");
  property p_rx; rx_byte_taken_o |-> spi_cs_n_i ##1 !rx_byte_taken_o; endproperty
  a_rx: assert property (p_rx) else $error("rx pulse wrong");
  property p_clr; (($past(status_o.evt) & ~status_o.evt) != 5'h00) |-> spi_cs_n_i; endproperty
  a_clr: assert property (p_clr) else $error("flag cleared in frame");
  property p_rst; $fell(rst_i) |-> cfg_o == CFG_DEFAULT && status_o.evt == 5'h00; endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  c_tx: cover property (tx_byte_valid_o);
  c_rx: cover property (rx_byte_taken_o);
  c_clr: cover property ($fell(status_o.evt.por_flag));
endmodule

// ---- bench/scrd_host.sv ----
`timescale 1ns/1ps
module scrd_host (
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // one frame of n bits; n other than 16 is a bad frame
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rd);
    rd = 16'h0000;
    #37.3 cs_n_o = 1'b0;
    #40;
    for (int i = 0; i < n; i++) begin
      sdi_o = w[15 - (i % 16)];
      #80 sck_o = 1'b1;
      rd = {rd[14:0], sdo_i};
      #80 sck_o = 1'b0;
    end
    #20 cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    #60;
  endtask
endmodule

// ---- bench/spi_command_register_decoder_tb.sv ----
`timescale 1ns/1ps
module spi_command_register_decoder_tb;
  import scrd_pkg::*;
  logic          core_clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic          sck, cs_n, sdi, sdo, oe, rx_tk, tx_v;
  scrd_evt_s     evt = '0;
  scrd_live_s    live = '0;
  logic [7:0]    rx_b = 8'h00;
  logic [7:0]    tx_b, b;
  scrd_cfg_t     cfg;
  scrd_gen_cfg_s gen;
  scrd_buf_cfg_s bcf;
  scrd_pwr_cfg_s pwr;
  scrd_status_s  st;
  int            num_errors = 0;
  int            comparisons = 0;
  int            cyc = 0;
  int            rx_n = 0;
  logic [31:0]   seed = 32'h0a4b8116;
  logic [7:0]    cm [14];
  logic [7:0]    tx_q [$];
  logic [15:0]   rd;
  logic [4:0]    ev;
  always #5 core_clk_i = ~core_clk_i;
  scrd_top dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .spi_sck_i(sck), .spi_cs_n_i(cs_n), .spi_sdi_i(sdi),
    .spi_sdo_o(sdo), .spi_sdo_oe_o(oe), .evt_i(evt), .live_i(live), .rx_byte_i(rx_b), .rx_byte_taken_o(rx_tk),
    .tx_byte_o(tx_b), .tx_byte_valid_o(tx_v), .cfg_o(cfg), .gen_cfg_o(gen), .buf_cfg_o(bcf), .pwr_cfg_o(pwr),
    .status_o(st));
  scrd_host host_u (.sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo));
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  function automatic logic [111:0] cpk();
    logic [111:0] r;
    for (int i = 0; i < 14; i++) r[i*8 +: 8] = cm[i];
    return r;
  endfunction
  task chk(input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task wr(input logic [3:0] i, input logic [7:0] p, input int n);
    host_u.xfer({4'h8, i, p}, n, rd);
    if (n == 16 && i < 14) cm[i] = p;
    chk(cfg, cpk());
  endtask
  task pulse(input logic [4:0] v);
    @(posedge core_clk_i);
    evt <= v;
    @(posedge core_clk_i);
    evt <= '0;
  endtask
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (tx_v === 1'b1) tx_q.push_back(tx_b);
    if (rx_tk === 1'b1) rx_n++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  initial begin
    for (int i = 0; i < 14; i++) cm[i] = CFG_DEFAULT[i];
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    chk(cfg, CFG_DEFAULT);
    chk(st.evt, 0);
    for (int i = 0; i < 14; i++) wr(i, rnd(), 16);
    chk({gen, bcf, pwr}, {cm[0], cm[6], cm[9]});
    b = rnd();
    wr(14, b, 16);
    chk(tx_q.size(), 1);
    chk(tx_q.pop_front(), b);
    @(posedge core_clk_i);
    rx_b <= rnd();
    wr(15, 8'h00, 16);
    chk(rd[7:0], rx_b);
    chk(rx_n, 1);
    wr(2, ~cm[2], 15);
    wr(3, ~cm[3], 17);
    host_u.xfer(16'h9155, 16, rd);
    chk(cfg, cpk());
    void'(rnd());
    // wake flag kept clear so the event raised during the read counts as new
    ev = (seed[4:0] | 5'h01) & 5'h1d;
    @(posedge core_clk_i);
    live <= seed[15:5];
    pulse(ev);
    repeat (4) @(posedge core_clk_i);
    chk(st, {ev, live});
    chk({st[8], st[3:0]}, {seed[13], seed[8:5]});
    host_u.xfer(16'h0000, 15, rd);
    chk(st.evt, ev);
    fork
      host_u.xfer(16'h0000, 16, rd);
      begin
        #800;
        pulse(5'h02);
      end
    join
    chk(rd[14:0], {ev, live[10:1]});
    repeat (2) @(posedge core_clk_i);
    chk(st.evt, 5'h02);
    end_sim();
  end
endmodule
bind scrd_top scrd_chk chk_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .spi_cs_n_i(spi_cs_n_i), .spi_sdo_o(spi_sdo_o),
  .spi_sdo_oe_o(spi_sdo_oe_o), .rx_byte_taken_o(rx_byte_taken_o), .tx_byte_valid_o(tx_byte_valid_o),
  .cfg_o(cfg_o), .gen_cfg_o(gen_cfg_o), .buf_cfg_o(buf_cfg_o), .pwr_cfg_o(pwr_cfg_o), .status_o(status_o));
